// file: hdl/fftsp_engine.sv
// Streaming FFT engine: ping-pong input banks, radix-2 DIT core, output buffer.
// How it works
// - Forward or inverse DIT FFT, 32..2048 points.
// - Samples are two's complement re/im pairs.
// - Dual input buffer, single output buffer.
// - Exactly N samples; results output after last stage.
// - After reset fill tables, then go ready.
// - Start returns to ready, discards buffers.
// - Sample taken on each cycle with valid and load high.
// - Full input bank starts processing automatically.
// - Load low after Nth sample only if other bank still full, high when free.
// - Source stops after a full burst.
// - Source idles with valid low.
// - Completed results stored, result ready raised.
// - Each output sample flagged valid.
// - Unread samples held until read enable.
// - Two input banks ping-pong, one butterfly.
`timescale 1ns/1ps
module fftsp_engine #(
    parameter int LOG_N = fftsp_pkg::LOG_N_DEF,
    parameter int B = fftsp_pkg::B_DEF
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic inverse_i,
    fftsp_if.engine bus
);
    localparam int N = 1 << LOG_N;
    localparam int HALF = N / 2;
    localparam int INIT_CYC = N * fftsp_pkg::INIT_CYC_PER_PT;

    if (LOG_N < fftsp_pkg::LOG_N_MIN || LOG_N > fftsp_pkg::LOG_N_MAX)
    begin
        $error("LOG_N out of range");
    end
    if (B < fftsp_pkg::B_MIN || B > fftsp_pkg::B_MAX)
    begin
        $error("B out of range");
    end

    typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_CALC, ST_DONE}
        fftsp_calc_t;
    typedef logic signed [B-1:0] fftsp_word_t;
    typedef logic signed [17:0] fftsp_coef_t;

    typedef struct packed {
        fftsp_calc_t cst;
        logic [LOG_N:0] init_cnt;
        logic [1:0] full;          // Per input bank: holds a frame.
        logic wbank;               // Bank being loaded.
        logic cbank;               // Bank being computed.
        logic [LOG_N-1:0] wptr;
        logic [LOG_N-1:0] stage;
        logic [LOG_N-2:0] bf;
        logic inv;
        logic out_full;
        logic [LOG_N:0] rptr;
        logic [N*2-1:0][B-1:0] bank_re;
        logic [N*2-1:0][B-1:0] bank_im;
        logic [N-1:0][B-1:0] obuf_re;
        logic [N-1:0][B-1:0] obuf_im;
        logic [HALF-1:0][17:0] tw_c;
        logic [HALF-1:0][17:0] tw_s;
        logic load;
        logic y_rdy;
        logic y_valid;
        logic [B-1:0] y_re;
        logic [B-1:0] y_im;
        logic ready;
    } fftsp_eng_t;

    fftsp_eng_t st_r;
    fftsp_eng_t st_nxt;

    // Bit reversal is used for the loading order only; output is read out in natural order.
    function automatic logic [LOG_N-1:0] fftsp_rev(input logic [LOG_N-1:0] a);
        logic [LOG_N-1:0] r;
        r = '0;
        for (int i = 0; i < LOG_N; i++)
            r[i] = a[LOG_N-1-i];
        return r;
    endfunction : fftsp_rev

    // Twiddle entry in Q1.16: cosine, or negated sine, of the phase of k.
    function automatic fftsp_coef_t fftsp_tw(input int k, input logic sn);
        real ph;
        ph = 6.283185307179586 * k / N;
        return sn ? fftsp_coef_t'($rtoi(-$sin(ph) * 65535.0))
                  : fftsp_coef_t'($rtoi($cos(ph) * 65535.0));
    endfunction : fftsp_tw

    ////////////////////////////////////////////////////////////////////////
    logic [LOG_N-1:0] ia;
    logic [LOG_N-1:0] ib;
    logic [LOG_N-2:0] tk;
    logic [LOG_N-1:0] half_m;
    logic signed [B+18:0] pr;
    logic signed [B+18:0] pi;
    logic signed [B:0] sum_re;
    logic signed [B:0] sum_im;
    logic signed [B:0] dif_re;
    logic signed [B:0] dif_im;
    logic signed [17:0] ws;

    always_comb
    begin
        half_m = LOG_N'(1) << st_r.stage;
        ia = LOG_N'(((st_r.bf >> st_r.stage) << (st_r.stage + 1)) |
             (st_r.bf & LOG_N'(half_m - 1)));
        ib = ia | half_m;
        tk = (LOG_N-1)'((st_r.bf & LOG_N'(half_m - 1))
             << (LOG_N - 1 - st_r.stage));
        ws = st_r.inv ? -$signed(st_r.tw_s[tk]) : $signed(st_r.tw_s[tk]);
        pr = $signed(st_r.bank_re[{st_r.cbank, ib}]) * $signed(st_r.tw_c[tk])
           - $signed(st_r.bank_im[{st_r.cbank, ib}]) * ws;
        pi = $signed(st_r.bank_re[{st_r.cbank, ib}]) * ws
           + $signed(st_r.bank_im[{st_r.cbank, ib}]) * $signed(st_r.tw_c[tk]);
        sum_re = $signed(st_r.bank_re[{st_r.cbank, ia}]) + (B+1)'(pr >>> 16);
        sum_im = $signed(st_r.bank_im[{st_r.cbank, ia}]) + (B+1)'(pi >>> 16);
        dif_re = $signed(st_r.bank_re[{st_r.cbank, ia}]) - (B+1)'(pr >>> 16);
        dif_im = $signed(st_r.bank_im[{st_r.cbank, ia}]) - (B+1)'(pi >>> 16);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.y_valid = 1'b0;
        unique case (st_r.cst)
            ST_INIT:
            begin
                if (st_r.init_cnt < (LOG_N+1)'(HALF))
                begin
                    st_nxt.tw_c[st_r.init_cnt[LOG_N-2:0]] =
                        fftsp_tw(int'(st_r.init_cnt), 1'b0);
                    st_nxt.tw_s[st_r.init_cnt[LOG_N-2:0]] =
                        fftsp_tw(int'(st_r.init_cnt), 1'b1);
                end
                st_nxt.init_cnt = st_r.init_cnt + 1'b1;
                if (st_r.init_cnt == (LOG_N+1)'(INIT_CYC - 1))
                begin
                    st_nxt.cst = ST_IDLE;
                    st_nxt.ready = 1'b1;
                    st_nxt.load = 1'b1;
                end
            end
            ST_IDLE:
            begin
                if (st_r.full[st_r.cbank])
                begin
                    st_nxt.cst = ST_CALC;
                    st_nxt.stage = '0;
                    st_nxt.bf = '0;
                    st_nxt.inv = inverse_i;
                end
            end
            // One butterfly per cycle in place.
            ST_CALC:
            begin
                st_nxt.bank_re[{st_r.cbank, ia}] = B'(sum_re >>> 1);
                st_nxt.bank_im[{st_r.cbank, ia}] = B'(sum_im >>> 1);
                st_nxt.bank_re[{st_r.cbank, ib}] = B'(dif_re >>> 1);
                st_nxt.bank_im[{st_r.cbank, ib}] = B'(dif_im >>> 1);
                st_nxt.bf = st_r.bf + 1'b1;
                if (st_r.bf == (LOG_N-1)'(HALF - 1))
                begin
                    st_nxt.stage = st_r.stage + 1'b1;
                    if (st_r.stage == LOG_N'(LOG_N - 1))
                        st_nxt.cst = ST_DONE;
                end
            end
            // Result waits for free output buffer.
            ST_DONE:
            begin
                if (!st_r.out_full)
                begin
                    for (int i = 0; i < N; i++)
                    begin
                        st_nxt.obuf_re[i] = st_r.bank_re[{st_r.cbank,
                            LOG_N'(i)}];
                        st_nxt.obuf_im[i] = st_r.bank_im[{st_r.cbank,
                            LOG_N'(i)}];
                    end
                    st_nxt.out_full = 1'b1;
                    st_nxt.y_rdy = 1'b1;
                    st_nxt.rptr = '0;
                    st_nxt.full[st_r.cbank] = 1'b0;
                    st_nxt.cbank = ~st_r.cbank;
                    st_nxt.cst = ST_IDLE;
                end
            end
        endcase

        if (st_r.cst != ST_INIT && st_r.load && bus.d_valid)
        begin
            st_nxt.bank_re[{st_r.wbank, fftsp_rev(st_r.wptr)}] = bus.d_re;
            st_nxt.bank_im[{st_r.wbank, fftsp_rev(st_r.wptr)}] = bus.d_im;
            st_nxt.wptr = st_r.wptr + 1'b1;
            if (st_r.wptr == LOG_N'(N - 1))
            begin
                st_nxt.full[st_r.wbank] = 1'b1;
                st_nxt.wbank = ~st_r.wbank;
                st_nxt.load = 1'b0;
            end
        end
        if (st_r.cst != ST_INIT && !st_nxt.full[st_nxt.wbank])
            st_nxt.load = 1'b1;

        // Hold output while read enable low.
        if (st_r.out_full && bus.read_y)
        begin
            st_nxt.y_valid = 1'b1;
            st_nxt.y_re = st_r.obuf_re[st_r.rptr[LOG_N-1:0]];
            st_nxt.y_im = st_r.obuf_im[st_r.rptr[LOG_N-1:0]];
            st_nxt.rptr = st_r.rptr + 1'b1;
            if (st_r.rptr == (LOG_N+1)'(N - 1))
            begin
                st_nxt.out_full = 1'b0;
                st_nxt.y_rdy = 1'b0;
            end
        end

        if (st_r.cst != ST_INIT && bus.start)
        begin
            st_nxt.cst = ST_IDLE;
            st_nxt.full = '0;
            st_nxt.wbank = 1'b0;
            st_nxt.cbank = 1'b0;
            st_nxt.wptr = '0;
            st_nxt.out_full = 1'b0;
            st_nxt.rptr = '0;
            st_nxt.load = 1'b1;
            st_nxt.y_rdy = 1'b0;
            st_nxt.y_valid = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= '0;
            st_r.cst <= ST_INIT;
            st_r.inv <= fftsp_pkg::INV_RST;
        end
        else if (clk_en_i)
            st_r <= st_nxt;
    end

    assign bus.load = st_r.load;
    assign bus.y_rdy = st_r.y_rdy;
    assign bus.y_valid = st_r.y_valid;
    assign bus.y_re = st_r.y_re;
    assign bus.y_im = st_r.y_im;
    assign bus.ready = st_r.ready;
endmodule : fftsp_engine

// file: hdl/fftsp_pkg.sv
// Shared constants of the streaming FFT engine host port.
package fftsp_pkg;
    // Transform size limits as log2 of the point count.
    localparam int LOG_N_MIN = 5;
    localparam int LOG_N_MAX = 11;
    localparam int LOG_N_DEF = 5;
    // Component width limits and default.
    localparam int B_MIN = 8;
    localparam int B_MAX = 16;
    localparam int B_DEF = 16;
    // Cycles spent filling the lookup tables after reset, per point.
    localparam int INIT_CYC_PER_PT = 1;
    // Cycles of butterfly work per stage, per point pair.
    localparam int STAGE_CYC_PER_PAIR = 1;
    // Reset value of the direction select (0 forward, 1 inverse).
    localparam logic INV_RST = 1'b0;
endpackage : fftsp_pkg

// file: hdl/fftsp_if.sv
// Interface joining the engine and the streaming host.
`timescale 1ns/1ps
interface fftsp_if #(
    parameter int B = fftsp_pkg::B_DEF
) (
    input wire logic core_clk_i
);
    logic start;
    logic d_valid;
    logic [B-1:0] d_re;
    logic [B-1:0] d_im;
    logic load;
    logic y_rdy;
    logic y_valid;
    logic [B-1:0] y_re;
    logic [B-1:0] y_im;
    logic read_y;
    logic ready;

    modport engine (
        input start, d_valid, d_re, d_im, read_y,
        output load, y_rdy, y_valid, y_re, y_im, ready
    );
    modport host (
        output start, d_valid, d_re, d_im, read_y,
        input load, y_rdy, y_valid, y_re, y_im, ready
    );
endinterface : fftsp_if

// file: hdl/fftsp_host.sv
// Streaming host: feeds bursts into the engine and drains result frames.
`timescale 1ns/1ps
module fftsp_host #(
    parameter int LOG_N = fftsp_pkg::LOG_N_DEF,
    parameter int B = fftsp_pkg::B_DEF
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic flush_i,
    input wire logic src_valid_i,
    input wire logic [B-1:0] src_re_i,
    input wire logic [B-1:0] src_im_i,
    output logic src_ready_o,
    input wire logic snk_ready_i,
    output logic snk_valid_o,
    output logic [B-1:0] snk_re_o,
    output logic [B-1:0] snk_im_o,
    output logic snk_frame_o,
    fftsp_if.host bus
);
    localparam int N = 1 << LOG_N;

    if (LOG_N < fftsp_pkg::LOG_N_MIN || LOG_N > fftsp_pkg::LOG_N_MAX)
    begin
        $error("LOG_N out of range");
    end
    if (B < fftsp_pkg::B_MIN || B > fftsp_pkg::B_MAX)
    begin
        $error("B out of range");
    end

    typedef struct packed {
        logic [LOG_N-1:0] cnt;
        logic start;
        logic d_valid;
        logic [B-1:0] d_re;
        logic [B-1:0] d_im;
        logic read_y;
        logic src_ready;
        logic snk_valid;
        logic [B-1:0] snk_re;
        logic [B-1:0] snk_im;
        logic snk_frame;
    } fftsp_host_t;

    fftsp_host_t st_r;
    fftsp_host_t st_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.start = flush_i;
        st_nxt.d_valid = 1'b0;
        // A sample is offered only when the engine can take it next cycle,
        // so the count stops the burst even though load lags one cycle.
        st_nxt.src_ready = bus.load && bus.ready && !flush_i &&
            !(st_r.d_valid && st_r.cnt == '0);
        if (st_r.src_ready && src_valid_i)
        begin
            st_nxt.d_valid = 1'b1;
            st_nxt.d_re = src_re_i;
            st_nxt.d_im = src_im_i;
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt == LOG_N'(N - 1))
                st_nxt.src_ready = 1'b0;
        end
        if (flush_i)
            st_nxt.cnt = '0;
        // Read only when sink can take.
        st_nxt.read_y = snk_ready_i;
        st_nxt.snk_valid = bus.y_valid;
        st_nxt.snk_re = bus.y_re;
        st_nxt.snk_im = bus.y_im;
        st_nxt.snk_frame = bus.y_rdy;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            st_r <= '0;
        else if (clk_en_i)
            st_r <= st_nxt;
    end

    assign bus.start = st_r.start;
    assign bus.d_valid = st_r.d_valid;
    assign bus.d_re = st_r.d_re;
    assign bus.d_im = st_r.d_im;
    assign bus.read_y = st_r.read_y;
    assign src_ready_o = st_r.src_ready;
    assign snk_valid_o = st_r.snk_valid;
    assign snk_re_o = st_r.snk_re;
    assign snk_im_o = st_r.snk_im;
    assign snk_frame_o = st_r.snk_frame;
endmodule : fftsp_host

// file: dv/fftsp_sva.sv
// Checker of the handshake rules between the engine and the host.
`timescale 1ns/1ps
module fftsp_sva #(
    parameter int LOG_N = fftsp_pkg::LOG_N_DEF,
    parameter int B = fftsp_pkg::B_DEF
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic start,
    input wire logic d_valid,
    input wire logic [B-1:0] d_re,
    input wire logic [B-1:0] d_im,
    input wire logic load,
    input wire logic y_rdy,
    input wire logic y_valid,
    input wire logic [B-1:0] y_re,
    input wire logic [B-1:0] y_im,
    input wire logic read_y,
    input wire logic ready
);
    localparam int N = 1 << LOG_N;
    int init_cnt;
    int in_cnt;
    int out_cnt;
    logic start_q;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    ////////////////////////////////////////////////////////////////////////
    // A flush clears the input and output counts, and a read in flight at the flush is
    // ignored for one more cycle so that a discarded frame leaves no trace.
    always_ff @(posedge core_clk_i)
    begin
        start_q <= start;
        if (sys_rst_i)
            init_cnt <= 0;
        else if (!ready)
            init_cnt <= init_cnt + 1;
        if (sys_rst_i || start)
            in_cnt <= 0;
        else if (d_valid && load && ready)
            in_cnt <= (in_cnt == N - 1) ? 0 : in_cnt + 1;
        if (sys_rst_i || start || start_q)
            out_cnt <= 0;
        else if (y_valid)
            out_cnt <= (out_cnt == N - 1) ? 0 : out_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_INIT_LEN: assert property ($rose(ready) |->
        init_cnt >= N - 1 && init_cnt <= N + 1) else $error("init length");
    AST_INIT_BOUND: assert property (!ready |-> init_cnt <= N + 2)
        else $error("never ready");
    AST_INIT_QUIET: assert property (!ready |->
        !load && !y_rdy && !y_valid) else $error("active during init");
    AST_READY_KEPT: assert property (ready |=> ready)
        else $error("ready dropped");
    AST_FLUSH: assert property (start && ready |=> load && !y_rdy)
        else $error("flush not done");
    AST_LOAD_FALL: assert property ($fell(load) |->
        $past(d_valid) && $past(ready) && $past(in_cnt) == N - 1)
        else $error("load fell off a burst end");
    AST_VALID_CAUSE: assert property (y_valid |->
        $past(y_rdy) && $past(read_y)) else $error("sample without a read");
    AST_READ_ANS: assert property (y_rdy && read_y && !start |=>
        y_valid) else $error("read not answered");
    AST_HOLD: assert property (y_rdy && !read_y && !start |=>
        y_rdy && !y_valid) else $error("frame not held");
    AST_FRAME_LEN: assert property (y_valid && !start_q |->
        y_rdy == (out_cnt != N - 1)) else $error("frame length");
    cover property (y_valid && out_cnt == N - 1);
    cover property ($fell(load));
    cover property (start && y_rdy);
endmodule : fftsp_sva

// file: dv/testbench.sv
// Self-checking bench for the engine joined to the streaming host.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
    localparam int LOG_N = 5;
    localparam int B = 16;
    localparam int N = 1 << LOG_N;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic flush_i = 1'b0;
    logic inverse_i = 1'b0;
    logic src_valid_i = 1'b0;
    logic [B-1:0] src_re_i = '0;
    logic [B-1:0] src_im_i = '0;
    logic snk_ready_i = 1'b0;
    logic src_ready_o;
    logic snk_valid_o;
    logic snk_frame_o;
    logic [B-1:0] snk_re_o;
    logic [B-1:0] snk_im_o;
    logic [B-1:0] exp_re_q[$];
    logic [B-1:0] exp_im_q[$];
    int err_count = 0;
    int n_tests = 0;
    always #25 core_clk_i = ~core_clk_i;
    fftsp_if #(.B(B)) bus_if (.core_clk_i(core_clk_i));
    fftsp_engine #(.LOG_N(LOG_N), .B(B)) fftsp_engine_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .inverse_i(inverse_i), .bus(bus_if));
    fftsp_host #(.LOG_N(LOG_N), .B(B)) fftsp_host_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .flush_i(flush_i), .src_valid_i(src_valid_i), .src_re_i(src_re_i),
        .src_im_i(src_im_i), .src_ready_o(src_ready_o),
        .snk_ready_i(snk_ready_i), .snk_valid_o(snk_valid_o),
        .snk_re_o(snk_re_o), .snk_im_o(snk_im_o),
        .snk_frame_o(snk_frame_o), .bus(bus_if));
    fftsp_sva #(.LOG_N(LOG_N), .B(B)) fftsp_sva_inst (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .start(bus_if.start), .d_valid(bus_if.d_valid), .d_re(bus_if.d_re),
        .d_im(bus_if.d_im), .load(bus_if.load), .y_rdy(bus_if.y_rdy),
        .y_valid(bus_if.y_valid), .y_re(bus_if.y_re), .y_im(bus_if.y_im),
        .read_y(bus_if.read_y), .ready(bus_if.ready));
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int k = 1);
        if (k > 0)
        begin
            repeat (k) @(posedge core_clk_i);
            #2;
        end
    endtask : tick
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // An impulse at sample 0 gives a flat spectrum, exact after the
    // halving at every stage, so no twiddle rounding enters the result.
    // Only such frames queue an expected value; others are judged apart.
    task automatic send_frame(input logic [B-1:0] re0,
        input logic [B-1:0] im0, input int gap, input int pos = 0);
        int w;
        if (pos == 0)
        begin
            exp_re_q.push_back($signed(re0) >>> LOG_N);
            exp_im_q.push_back($signed(im0) >>> LOG_N);
        end
        for (int i = 0; i < N; i++)
        begin
            src_valid_i = 1'b1;
            src_re_i = (i == pos) ? re0 : '0;
            src_im_i = (i == pos) ? im0 : '0;
            w = 0;
            while (src_ready_o !== 1'b1 && w < 2000)
            begin
                tick();
                w++;
            end
            `CHK(src_ready_o, 1'b1)
            tick();
            if (gap > 0)
            begin
                src_valid_i = 1'b0;
                tick(gap);
            end
        end
        src_valid_i = 1'b0;
    endtask : send_frame
    task automatic wait_frame();
        int w;
        w = 0;
        while (snk_frame_o !== 1'b1 && w < 2000)
        begin
            tick();
            w++;
        end
        `CHK(snk_frame_o, 1'b1)
    endtask : wait_frame
    // The sink stalls for 20 cycles from cycle p0; a p0 of -20 or less never stalls.
    task automatic read_frames(input int nf, input int p0);
        int n;
        int cyc;
        logic [B-1:0] er;
        logic [B-1:0] ei;
        n = 0;
        cyc = 0;
        while (n < nf * N && cyc < 5000)
        begin
            snk_ready_i = !(cyc >= p0 && cyc < p0 + 20);
            tick();
            cyc++;
            if (cyc == p0 + 12)
            begin
                `CHK(snk_valid_o, 1'b0)
                `CHK(snk_frame_o, 1'b1)
            end
            if (snk_valid_o === 1'b1)
            begin
                if (n % N == 0)
                begin
                    er = exp_re_q.pop_front();
                    ei = exp_im_q.pop_front();
                end
                `CHK(snk_re_o, er)
                `CHK(snk_im_o, ei)
                n++;
            end
        end
        `CHK(n, nf * N)
        snk_ready_i = 1'b0;
        tick(6);
        `CHK(snk_valid_o, 1'b0)
    endtask : read_frames
    // Bin N/4 of a real impulse at sample 1 is -j forward and +j inverse,
    // so the sign of its imaginary part tells the direction apart.
    task automatic read_quarter(input logic neg);
        int n;
        int cyc;
        n = 0;
        cyc = 0;
        snk_ready_i = 1'b1;
        while (n < N && cyc < 2000)
        begin
            tick();
            cyc++;
            if (snk_valid_o === 1'b1)
            begin
                if (n == N / 4)
                begin
                    `CHK(snk_re_o, {B{1'b0}})
                    `CHK(snk_im_o[B-1], neg)
                end
                n++;
            end
        end
        `CHK(n, N)
        snk_ready_i = 1'b0;
        tick(6);
    endtask : read_quarter
    ////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        int w;
        w = 0;
        while (src_ready_o !== 1'b1 && w < 100)
        begin
            tick();
            w++;
        end
        `CHK(w >= N && w <= N + 4, 1'b1)
        `CHK(snk_frame_o, 1'b0)
        $display("test init done");
    endtask : t_init
    task automatic t_modes();
        for (int m = 0; m < 2; m++)
        begin
            inverse_i = m[0];
            send_frame(16'h0400, 16'hfc00, 0);
            read_frames(1, -100);
            send_frame(16'h0400, 16'h0000, 0, 1);
            read_quarter(!m[0]);
        end
        inverse_i = 1'b0;
        $display("test modes done");
    endtask : t_modes
    task automatic t_gaps_stall();
        send_frame(16'hf800, 16'h0800, 3);
        wait_frame();
        read_frames(1, 8);
        $display("test gaps and stall done");
    endtask : t_gaps_stall
    task automatic t_backlog();
        int hi;
        send_frame(16'h0400, 16'h0000, 0);
        send_frame(16'h0800, 16'h0400, 0);
        send_frame(16'hf800, 16'h0c00, 0);
        hi = 0;
        repeat (200)
        begin
            tick();
            hi += (src_ready_o === 1'b1);
        end
        `CHK(hi, 0)
        read_frames(3, -100);
        tick(4);
        `CHK(src_ready_o, 1'b1)
        $display("test backlog done");
    endtask : t_backlog
    task automatic t_flush();
        send_frame(16'h0400, 16'h0400, 0);
        wait_frame();
        flush_i = 1'b1;
        tick();
        flush_i = 1'b0;
        tick(4);
        `CHK(snk_frame_o, 1'b0)
        `CHK(src_ready_o, 1'b1)
        exp_re_q.delete();
        exp_im_q.delete();
        snk_ready_i = 1'b1;
        tick(10);
        `CHK(snk_valid_o, 1'b0)
        snk_ready_i = 1'b0;
        send_frame(16'h0c00, 16'hf400, 1);
        read_frames(1, -100);
        $display("test flush done");
    endtask : t_flush
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(5);
        sys_rst_i = 1'b0;
        t_init();
        t_modes();
        t_gaps_stall();
        t_backlog();
        t_flush();
        test_done();
    end
    // The tests need a few thousand cycles; this cuts a hang short.
    initial
    begin
        tick(20000);
        err_count++;
        test_done();
    end
endmodule : testbench
